// file: clock_sync_regs.svh
`ifndef CLOCK_SYNC_REGS_SVH
`define CLOCK_SYNC_REGS_SVH

`define SYS_CLK_KHZ        8192
`define FRAME_NS           125000
`define PEER_SYNC_NS       488
`define MFRAME_NS          4000000
`define NS_TO_SYS(ns)      (((ns) * `SYS_CLK_KHZ + 500000) / 1000000)
`define FRAME_PERIODS      `NS_TO_SYS(`FRAME_NS)
`define PEER_SYNC_PERIODS  `NS_TO_SYS(`PEER_SYNC_NS)
`define MFRAME_FRAMES      (`MFRAME_NS / `FRAME_NS)
`define REF_SEL_EXT_BIT    1
`define REF_SEL_NEAR_BIT   0
`define BAL_WIDTH          8

`endif

// file: clock_sync_pkg.sv
package clock_sync_pkg;

    typedef enum logic [1:0] {
        DLY_LONG_SLAVE  = 2'b00,
        DLY_LONG_MASTER = 2'b01,
        DLY_RESERVED    = 2'b10,
        DLY_SHORT       = 2'b11
    } delay_mode_t;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_RUN   = 2'b01
    } strap_state_t;

    typedef struct packed {
        logic [9:0] pcm_rx;
        logic [9:0] pcm_tx;
        logic [9:0] ctrl;
    } align_cfg_t;

    typedef struct packed {
        logic sys_clk;
        logic half_rate;
        logic fast_ctrl;
    } pwr_mask_t;

endpackage : clock_sync_pkg

// file: clock_and_frame_sync_unit.sv
`timescale 1ns/1ps
`include "clock_sync_regs.svh"

module clock_and_frame_sync_unit (
    // Clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      power_on_reset_n,
    // Clock sources and selection
    input  wire logic                      sysclk_source_select,
    input  wire logic                      fast_operating_clk,
    input  wire logic                      crystal_osc_clk,
    input  wire logic                      sys_clk_in,
    input  wire clock_sync_pkg::pwr_mask_t pwr_mask_in,
    // Frame sync
    input  wire logic                      frame_sync_in,
    input  wire logic                      peer_sync_in,
    input  wire logic                      ctrl_highway_used_in,
    input  wire logic                      internal_frame_ref_in,
    input  wire logic                      frame_sync_wide_in,
    input  wire clock_sync_pkg::align_cfg_t align_cfg_in,
    // References
    input  wire logic                      far_ref_clk,
    input  wire logic                      near_ref_clk,
    input  wire logic                      ext_ref_clk,
    input  wire logic                      far_rx_frame_pulse,
    input  wire logic                      near_rx_frame_pulse,
    input  wire logic [6:5]                ref_select_ctrl,
    // Straps
    input  wire logic                      delay_strap_lo,
    input  wire logic                      delay_strap_hi,
    // Clock outputs
    output logic                           sys_clk_out,
    output logic                           half_rate_clk_out,
    output logic                           fast_osc_ctrl_out,
    output logic                           crystal_osc_ctrl_out,
    // Frame and delay mode outputs
    output logic                           frame_sync_out,
    output logic                           peer_sync_out,
    output logic [9:0]                     frame_pos_out,
    output logic [4:0]                     multiframe_out,
    output logic [2:0]                     highway_start_out,
    output logic                           multiframe_start_out,
    output logic                           rx_ts0_mark_out,
    output clock_sync_pkg::delay_mode_t    delay_mode_out
);

    // ********************************
    // Edge detection
    // ********************************
    logic rst;
    logic fast_prev_q, xtal_prev_q, sysin_prev_q, fsync_prev_q, peer_prev_q;
    logic ref_prev_q, rxfp_prev_q;
    logic fast_rise, xtal_rise, sysin_rise, fsync_rise, peer_rise, ref_rise, rxfp_rise;
    logic ref_sel, rxfp_sel;

    assign rst = sys_rst_in | ~power_on_reset_n;

    assign ref_sel = ref_select_ctrl[6] ? ext_ref_clk :
                     (ref_select_ctrl[5] ? near_ref_clk : far_ref_clk);
    assign rxfp_sel = ref_select_ctrl[5] ? near_rx_frame_pulse : far_rx_frame_pulse;

    assign fast_rise  = fast_operating_clk & ~fast_prev_q;
    assign xtal_rise  = crystal_osc_clk & ~xtal_prev_q;
    assign sysin_rise = sys_clk_in & ~sysin_prev_q;
    assign fsync_rise = frame_sync_in & ~fsync_prev_q;
    assign peer_rise  = peer_sync_in & ~peer_prev_q;
    assign ref_rise   = ref_sel & ~ref_prev_q;
    assign rxfp_rise  = rxfp_sel & ~rxfp_prev_q;

    always_ff @(posedge clk_in) begin
        if (rst) begin
            fast_prev_q  <= 1'b0;
            xtal_prev_q  <= 1'b0;
            sysin_prev_q <= 1'b0;
            fsync_prev_q <= 1'b1;
            peer_prev_q  <= 1'b1;
            ref_prev_q   <= 1'b1;
            rxfp_prev_q  <= 1'b1;
        end else begin
            fast_prev_q  <= fast_operating_clk;
            xtal_prev_q  <= crystal_osc_clk;
            sysin_prev_q <= sys_clk_in;
            fsync_prev_q <= frame_sync_in;
            peer_prev_q  <= peer_sync_in;
            ref_prev_q   <= ref_sel;
            rxfp_prev_q  <= rxfp_sel;
        end
    end

    // ********************************
    // Strap capture
    // ********************************
    clock_sync_pkg::strap_state_t st_q, st_d;
    clock_sync_pkg::delay_mode_t  mode_q, mode_d;
    logic                         slave;

    always_comb begin
        st_d   = st_q;
        mode_d = mode_q;
        case (st_q)
            clock_sync_pkg::ST_STRAP: begin
                mode_d = clock_sync_pkg::delay_mode_t'({delay_strap_hi, delay_strap_lo});
                st_d   = clock_sync_pkg::ST_RUN;
            end
            clock_sync_pkg::ST_RUN: begin
                st_d = clock_sync_pkg::ST_RUN;
            end
            default: begin
                st_d = clock_sync_pkg::ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst) begin
            st_q   <= clock_sync_pkg::ST_STRAP;
            mode_q <= clock_sync_pkg::DLY_SHORT;
        end else begin
            st_q   <= st_d;
            mode_q <= mode_d;
        end
    end

    assign slave          = (mode_q == clock_sync_pkg::DLY_LONG_SLAVE);
    assign delay_mode_out = mode_q;

    // ********************************
    // Clock dividers and oscillator control
    // ********************************
    logic [1:0] div_q, div_d;
    logic       half_q, half_d, fctl_q, fctl_d;
    logic       sco_q, sco_d, hro_q, hro_d, fco_q, fco_d;
    logic [2:0] x8_q, x8_d;
    logic signed [`BAL_WIDTH-1:0] bal_q, bal_d;
    logic       cco_q, cco_d;
    logic       x8_rise;

    assign x8_rise = xtal_rise && (x8_q == 3'h3);

    always_comb begin
        div_d  = div_q;
        half_d = half_q;
        fctl_d = fctl_q;
        x8_d   = x8_q;
        bal_d  = bal_q;
        if (slave && peer_rise) begin
            div_d = 2'h0;
        end else if (sysclk_source_select && fast_rise) begin
            div_d = div_q + 2'h1;
        end else if (!sysclk_source_select && xtal_rise) begin
            div_d = div_q + 2'h2;
        end
        if (sysin_rise) begin
            half_d = ~half_q;
            fctl_d = ~div_q[1];
        end
        if (xtal_rise) begin
            x8_d = x8_q + 3'h1;
        end
        if (ref_rise && !x8_rise && bal_q != 8'sh7f) begin
            bal_d = bal_q + 8'sh01;
        end else if (x8_rise && !ref_rise && bal_q != -8'sh80) begin
            bal_d = bal_q - 8'sh01;
        end
        sco_d = div_d[1] & ~pwr_mask_in.sys_clk;
        hro_d = half_d & ~pwr_mask_in.half_rate;
        fco_d = fctl_d & ~pwr_mask_in.fast_ctrl & ~slave;
        cco_d = ~bal_d[`BAL_WIDTH-1];
    end

    always_ff @(posedge clk_in) begin
        if (rst) begin
            div_q  <= 2'h0;
            half_q <= 1'b0;
            fctl_q <= 1'b0;
            x8_q   <= 3'h0;
            bal_q  <= '0;
            sco_q  <= 1'b0;
            hro_q  <= 1'b0;
            fco_q  <= 1'b0;
            cco_q  <= 1'b1;
        end else begin
            div_q  <= div_d;
            half_q <= half_d;
            fctl_q <= fctl_d;
            x8_q   <= x8_d;
            bal_q  <= bal_d;
            sco_q  <= sco_d;
            hro_q  <= hro_d;
            fco_q  <= fco_d;
            cco_q  <= cco_d;
        end
    end

    assign sys_clk_out          = sco_q;
    assign half_rate_clk_out    = hro_q;
    assign fast_osc_ctrl_out    = fco_q;
    assign crystal_osc_ctrl_out = cco_q;

    // ********************************
    // Frame timing
    // ********************************
    logic [9:0] pos_q, pos_d;
    logic [4:0] mf_q, mf_d;
    logic       fso_q, fso_d, pso_q, pso_d, mfs_q, mfs_d, rxm_q, rxm_d;
    logic [2:0] hws_q, hws_d;
    logic       use_internal, realign;

    assign use_internal = !ctrl_highway_used_in && internal_frame_ref_in;
    assign realign = (!use_internal && fsync_rise) || (slave && peer_rise);

    always_comb begin
        pos_d = pos_q;
        mf_d  = mf_q;
        if (realign) begin
            pos_d = 10'h0;
            if (fsync_rise && ctrl_highway_used_in) begin
                mf_d = 5'h0;
            end
        end else if (sysin_rise) begin
            pos_d = (pos_q == 10'(`FRAME_PERIODS - 1)) ? 10'h0 : pos_q + 10'h1;
            if (pos_q == 10'(`FRAME_PERIODS - 1)) begin
                mf_d = (mf_q == 5'(`MFRAME_FRAMES - 1)) ? 5'h0 : mf_q + 5'h1;
            end
        end
        fso_d = (pos_d == 10'h0) || (frame_sync_wide_in && pos_d == 10'h1);
        pso_d = !slave && (pos_d < 10'(`PEER_SYNC_PERIODS));
        hws_d = 3'h0;
        mfs_d = 1'b0;
        if (sysin_rise) begin
            hws_d[0] = (pos_q == align_cfg_in.pcm_rx);
            hws_d[1] = (pos_q == align_cfg_in.pcm_tx);
            hws_d[2] = (pos_q == align_cfg_in.ctrl);
            mfs_d    = hws_d[2] && (mf_q == 5'h0) && ctrl_highway_used_in;
        end
        rxm_d = rxfp_rise;
    end

    always_ff @(posedge clk_in) begin
        if (rst) begin
            pos_q <= 10'h0;
            mf_q  <= 5'h0;
            fso_q <= 1'b0;
            pso_q <= 1'b0;
            hws_q <= 3'h0;
            mfs_q <= 1'b0;
            rxm_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            mf_q  <= mf_d;
            fso_q <= fso_d;
            pso_q <= pso_d;
            hws_q <= hws_d;
            mfs_q <= mfs_d;
            rxm_q <= rxm_d;
        end
    end

    assign frame_sync_out       = fso_q;
    assign peer_sync_out        = pso_q;
    assign frame_pos_out        = pos_q;
    assign multiframe_out       = mf_q;
    assign highway_start_out    = hws_q;
    assign multiframe_start_out = mfs_q;
    assign rx_ts0_mark_out      = rxm_q;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst);

    sequence fast_step_s;
        sysclk_source_select && fast_rise && !(slave && peer_rise);
    endsequence

    sequence realign_s;
        !use_internal && fsync_rise;
    endsequence

    div_by_four_a: assert property (fast_step_s |=> div_q == $past(div_q) + 2'h1)
        else $error("fast clock divider did not step by one");
    div_by_two_a: assert property (
        !sysclk_source_select && xtal_rise && !(slave && peer_rise) |=> div_q == $past(div_q) + 2'h2)
        else $error("crystal clock divider did not step by two");
    half_rate_a: assert property (
        !pwr_mask_in.half_rate ##1 (sysin_rise && !pwr_mask_in.half_rate) |=> hro_q != $past(hro_q))
        else $error("half rate clock did not toggle");
    sys_mask_a: assert property (pwr_mask_in.sys_clk |=> !sys_clk_out)
        else $error("masked system clock output active");
    frame_align_a: assert property (realign_s |=> pos_q == 10'h0 && fso_q)
        else $error("frame sync input did not realign frame");
    sync_width_a: assert property (
        sysin_rise && pos_q == 10'h0 && frame_sync_wide_in && !realign |=> ##1 frame_sync_out)
        else $error("wide frame sync lost its second period");
    peer_pulse_a: assert property (
        !slave && pos_q == 10'h3 && !realign && !sysin_rise |=> peer_sync_out)
        else $error("peer sync pulse too short");
    peer_follow_a: assert property (slave && peer_rise |=> div_q == 2'h0 && pos_q == 10'h0)
        else $error("slave did not follow peer sync");
    rx_mark_a: assert property (
        ref_select_ctrl[5] && near_rx_frame_pulse && !rxfp_prev_q |=> rx_ts0_mark_out)
        else $error("near receive frame pulse not marked");
    strap_hold_a: assert property (st_q == clock_sync_pkg::ST_RUN |=> $stable(delay_mode_out))
        else $error("delay mode changed after capture");

endmodule : clock_and_frame_sync_unit

// file: clock_sync_partner.sv
`timescale 1ns/1ps
module clock_sync_partner #(
    parameter int PULSE_CYC = 98
) (
    // Clock
    input  wire logic       clk_in,
    // Controls
    input  wire logic [2:0] ref_en_in,
    input  wire logic [3:0] pulse_req_in,
    // Line side
    output logic            fast_clk_out,
    output logic            xtal_clk_out,
    output logic            sys_clk_out,
    output logic [2:0]      ref_clk_out,
    output logic [3:0]      pulse_out
);
    logic [11:0] tick_q = 12'h000;
    logic [3:0]  req_q  = 4'h0;
    int          cnt_q [4] = '{0, 0, 0, 0};

    always_ff @(posedge clk_in) begin
        tick_q <= tick_q + 12'h001;
        req_q  <= pulse_req_in;
        for (int i = 0; i < 4; i++) begin
            if (pulse_req_in[i] && !req_q[i]) begin
                cnt_q[i] <= PULSE_CYC;
            end else if (cnt_q[i] > 0) begin
                cnt_q[i] <= cnt_q[i] - 1;
            end
        end
    end

    assign fast_clk_out = tick_q[1];
    assign xtal_clk_out = tick_q[2];
    assign sys_clk_out  = tick_q[2] ^ tick_q[1];
    // Stopped references rest at the pull-up level
    assign ref_clk_out  = ~ref_en_in | {3{tick_q[2]}};

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pulse_out[i] = cnt_q[i] > 0;
        end
    end
endmodule : clock_sync_partner

// file: tb_clock_and_frame_sync_unit.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_clock_and_frame_sync_unit;
    typedef struct packed {logic hi; logic lo; logic s5; logic [1:0] mode;} row_t;
    logic clk_in = 1'h0, sys_rst_in = 1'h1, por_n = 1'h1, src_sel = 1'h1;
    logic int_ref = 1'h0, wide = 1'h0, s_hi = 1'h1, s_lo = 1'h1, sco, hro, fco, cco, fso, pso, rxm;
    logic [6:5] ref_sel = 2'h0;
    logic [2:0] ref_en = 3'h0;
    logic [3:0] req = 4'h0;
    logic [4:0] acc;
    logic [9:0] pos;
    clock_sync_pkg::pwr_mask_t mask = '0;
    clock_sync_pkg::delay_mode_t mode;
    clock_sync_pkg::align_cfg_t align = '0;
    logic hwy = 1'h0, mfs;
    logic [2:0] hws;
    logic [3:0] hacc;
    logic [4:0] mf;
    wire logic fast, xtal, sclk;
    wire logic [2:0] refs;
    wire logic [3:0] pul;
    wire logic [3:0] outs = {pso, fso, hro, sco};
    wire logic [2:0] srcs = {sclk, xtal, fast};
    int err_count = 0, comparisons = 0, cyc = 0, n, hcnt;
    row_t rows [4] = '{'{1'h1, 1'h1, 1'h0, 2'h3}, '{1'h0, 1'h1, 1'h1, 2'h1},
                       '{1'h1, 1'h0, 1'h0, 2'h2}, '{1'h0, 1'h0, 1'h1, 2'h0}};

    clock_sync_partner partner (.clk_in(clk_in), .ref_en_in(ref_en), .pulse_req_in(req), .fast_clk_out(fast),
        .xtal_clk_out(xtal), .sys_clk_out(sclk), .ref_clk_out(refs), .pulse_out(pul));

    clock_and_frame_sync_unit uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .power_on_reset_n(por_n),
        .sysclk_source_select(src_sel), .fast_operating_clk(fast), .crystal_osc_clk(xtal),
        .sys_clk_in(sclk), .pwr_mask_in(mask), .frame_sync_in(pul[0]), .peer_sync_in(pul[1]),
        .ctrl_highway_used_in(hwy), .internal_frame_ref_in(int_ref), .frame_sync_wide_in(wide),
        .align_cfg_in(align), .far_ref_clk(refs[0]), .near_ref_clk(refs[1]), .ext_ref_clk(refs[2]),
        .far_rx_frame_pulse(pul[2]), .near_rx_frame_pulse(pul[3]), .ref_select_ctrl(ref_sel),
        .delay_strap_lo(s_lo), .delay_strap_hi(s_hi), .sys_clk_out(sco), .half_rate_clk_out(hro),
        .fast_osc_ctrl_out(fco), .crystal_osc_ctrl_out(cco), .frame_sync_out(fso), .peer_sync_out(pso),
        .frame_pos_out(pos), .multiframe_out(mf), .highway_start_out(hws), .multiframe_start_out(mfs),
        .rx_ts0_mark_out(rxm), .delay_mode_out(mode));

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 100000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : step

    task automatic do_reset(input bit por);
        sys_rst_in = !por;
        por_n = !por;
        step(8);
        sys_rst_in = 1'h0;
        por_n = 1'h1;
        step(2);
    endtask : do_reset

    task automatic pulse(input int i);
        req[i] = 1'h1;
        step(1);
        req[i] = 1'h0;
    endtask : pulse

    // Collects which events showed up over k cycles
    task automatic watch(input int k, output logic [4:0] a);
        a = '0;
        repeat (k) begin
            step(1);
            a = a | {fco, sco | hro, pos === 10'h000, pso, rxm};
        end
    endtask : watch

    // Source rises (or cycles if s < 0) from a rise of output o to its fall or next rise
    task automatic measure(input int o, input int s, input bit full, output int cnt);
        int g;
        logic po, ps;
        cnt = 0;
        g = 0;
        po = outs[o];
        while (!(outs[o] && !po) && g < 10000) begin
            po = outs[o];
            step(1);
            g++;
        end
        do begin
            po = outs[o];
            ps = (s < 0) ? 1'h0 : srcs[s];
            step(1);
            g++;
            cnt += (s < 0) ? 1 : int'(srcs[s] && !ps);
        end while ((full ? !(outs[o] && !po) : outs[o]) && g < 20000);
    endtask : measure

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial begin
        for (int i = 0; i < 4; i++) begin
            s_hi = rows[i].hi;
            s_lo = rows[i].lo;
            ref_sel = {1'h0, rows[i].s5};
            do_reset(i[0]);
            `CHK("delay_mode", rows[i].mode, mode)
            pulse(2);
            watch(110, acc);
            `CHK("rx_far", !rows[i].s5, acc[0])
            pulse(3);
            watch(110, acc);
            `CHK("rx_near", rows[i].s5, acc[0])
            $display("test row %0d done", i);
        end
        pulse(1);
        watch(40, acc);
        `CHK("peer_realign", 1'h1, acc[2])
        `CHK("peer_silent", 1'h0, acc[1])
        `CHK("slave_fast_ctrl", 1'h0, acc[4])
        $display("test slave done");
        s_hi = 1'h0;
        s_lo = 1'h1;
        sys_rst_in = 1'h1;
        step(8);
        `CHK("rst_pos", 10'h000, pos)
        `CHK("rst_fso", 1'h0, fso | pso | sco)
        `CHK("rst_cco", 1'h1, cco)
        `CHK("rst_mode", clock_sync_pkg::DLY_SHORT, mode)
        sys_rst_in = 1'h0;
        step(2);
        $display("test reset done");
        measure(0, 0, 1, n);
        `CHK("div4", 4, n)
        src_sel = 1'h0;
        step(4);
        measure(0, 1, 1, n);
        `CHK("div2", 2, n)
        measure(1, 2, 1, n);
        `CHK("half_rate", 2, n)
        mask = '1;
        step(3);
        watch(40, acc);
        `CHK("masked", 2'h0, acc[4:3])
        mask = '0;
        watch(40, acc);
        `CHK("unmasked", 2'h3, acc[4:3])
        $display("test clocks done");
        measure(2, -1, 0, n);
        `CHK("fso_narrow", 8, n)
        pulse(0);
        watch(4, acc);
        `CHK("frame_realign", 1'h1, acc[2])
        step(120);
        int_ref = 1'h1;
        pulse(0);
        watch(6, acc);
        `CHK("int_ref", 1'h0, acc[2])
        int_ref = 1'h0;
        wide = 1'h1;
        measure(2, -1, 0, n);
        `CHK("fso_wide", 16, n)
        measure(3, -1, 0, n);
        `CHK("peer_width", 32, n)
        measure(2, -1, 1, n);
        `CHK("frame_period", 8192, n)
        step(80);
        `CHK("pos_count", 10'h00a, pos)
        $display("test frame done");
        ref_en = 3'h1;
        ref_sel = 2'h0;
        step(2000);
        `CHK("ref_far", 1'h1, cco)
        ref_sel = 2'h1;
        step(10000);
        `CHK("ref_near", 1'h0, cco)
        ref_en = 3'h4;
        ref_sel = 2'h2;
        step(2500);
        `CHK("ref_ext", 1'h1, cco)
        $display("test reference done");
        hwy = 1'h1;
        int_ref = 1'h1;
        align = '{pcm_rx: 10'h005, pcm_tx: 10'h006, ctrl: 10'h007};
        pulse(0);
        watch(4, acc);
        `CHK("hwy_realign", 1'h1, acc[2])
        `CHK("mf_zero", 5'h00, mf)
        hacc = '0;
        hcnt = 0;
        repeat (80) begin
            step(1);
            hacc = hacc | {mfs, hws};
            hcnt += $countones({mfs, hws});
        end
        `CHK("hwy_starts", 4'hf, hacc)
        `CHK("hwy_pulses", 4, hcnt)
        $display("test highway done");
        finish_test();
    end
endmodule : tb_clock_and_frame_sync_unit
